// >>> hdl/wdt_pkg.sv
// package: port map, register layout and timing constants for the config-port watchdog
package wdt_pkg;
   // ============================================================
   // io ports
   localparam logic [7:0] PORT_INDEX      = 8'h2E;
   localparam logic [7:0] PORT_DATA       = 8'h2F;
   // ============================================================
   // key values written to the index port
   localparam logic [7:0] KEY_UNLOCK      = 8'h87;
   localparam logic [7:0] KEY_LOCK        = 8'hAA;
   // ============================================================
   // register indices
   localparam logic [7:0] REG_FUNC_SEL    = 8'h07;
   localparam logic [7:0] REG_FUNC_ACT    = 8'h30;
   localparam logic [7:0] REG_UNIT_CFG    = 8'hF5;
   localparam logic [7:0] REG_COUNT       = 8'hF6;
   localparam logic [7:0] REG_CTRL_STAT   = 8'hF7;
   localparam logic [7:0] FUNC_WATCHDOG   = 8'h08;
   // ============================================================
   // field positions
   localparam int         BIT_ACT_EN      = 0;
   localparam int         BIT_UNIT_MIN    = 3;
   localparam int         BIT_FAST        = 4;
   localparam int         BIT_STATUS      = 4;
   localparam int         BIT_FORCE       = 5;
   localparam int         BIT_KBD_EN      = 6;
   // ============================================================
   // reset values
   localparam logic [7:0] RST_FUNC_SEL    = 8'h00;
   localparam logic [7:0] RST_FUNC_ACT    = 8'h00;
   localparam logic [7:0] RST_UNIT_CFG    = 8'h00;
   localparam logic [7:0] RST_COUNT       = 8'h00;
   localparam logic [7:0] RST_CTRL        = 8'h00;
   // ============================================================
   // timing
   localparam longint     CLK_HZ          = 20000000;
   localparam longint     SEC_S           = 1;
   localparam longint     MIN_S           = 60;
   localparam longint     FAST_DIV        = 1000;
   localparam longint     SEC_CYC         = CLK_HZ * SEC_S;
   localparam longint     MS_CYC          = SEC_CYC / FAST_DIV;
   localparam longint     MIN_TICKS       = MIN_S;
   // host wait between read strobe and read data
   localparam int         RD_LAT          = 1;
endpackage

// >>> hdl/wdt_if.sv
// interface: i/o port cycles between host controller and watchdog device
`timescale 1ns/1ps
interface wdt_if;
   logic [7:0] io_addr;
   logic [7:0] io_wdata;
   logic       io_wr;
   logic       io_rd;
   logic [7:0] io_rdata;
   logic       kbd_activity;

   modport device (
      input  io_addr,
      input  io_wdata,
      input  io_wr,
      input  io_rd,
      output io_rdata,
      input  kbd_activity
   );
   modport host (
      output io_addr,
      output io_wdata,
      output io_wr,
      output io_rd,
      input  io_rdata,
      output kbd_activity
   );
endinterface

// >>> hdl/tick_gen.sv
// prescaler: produces one-cycle unit ticks for the watchdog countdown
`timescale 1ns/1ps
module tick_gen #(
   parameter longint SEC_CYC = wdt_pkg::SEC_CYC,
   parameter longint MS_CYC  = wdt_pkg::MS_CYC
) (
   input  wire logic ref_clk,
   input  wire logic rst_b,
   input  wire logic clr,
   input  wire logic minutes,
   input  wire logic fast,
   output logic      tick
);
   // elaboration guard: counts must fit the 32-bit prescaler
   if (MS_CYC < 1 || SEC_CYC < MS_CYC || SEC_CYC > 64'h00000000FFFFFFFF) begin : g_bad_prescale
      $error("tick_gen: bad prescale");
   end

   logic [31:0] pre_r;
   logic [31:0] pre_nxt;
   logic [7:0]  min_r;
   logic [7:0]  min_nxt;
   logic [31:0] pre_top;
   logic        pre_wrap;
   logic        min_wrap;

   // ============================================================
   // base period: one second or one millisecond of ref_clk
   assign pre_top  = fast ? 32'(MS_CYC - 1) : 32'(SEC_CYC - 1);
   assign pre_wrap = (pre_r >= pre_top);
   assign min_wrap = (min_r == 8'(wdt_pkg::MIN_TICKS - 1));
   assign pre_nxt  = (clr || pre_wrap) ? 32'h0 : pre_r + 32'h1;
   assign min_nxt  = clr ? 8'h00 : (pre_wrap ? (min_wrap ? 8'h00 : min_r + 8'h01) : min_r);

   // minutes mode stretches every base period by sixty
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_r <= 32'h0;
         min_r <= 8'h00;
         tick  <= 1'b0;
      end else begin
         pre_r <= pre_nxt;
         min_r <= minutes ? min_nxt : 8'h00;
         tick  <= !clr && pre_wrap && (!minutes || min_wrap);
      end
   end
endmodule

// >>> hdl/wdt_device.sv
// device end: locked index/data config space holding the watchdog timer
`timescale 1ns/1ps
// ============================================================
// Overview of operation
// [RULE_01] index port 2E, data port 2F
// [RULE_02] host writes index before each data access
// [RULE_03] two 87 writes unlock config space
// [RULE_04] AA on index port relocks
// [RULE_05] function 08 maps watchdog registers
// [RULE_06] activation bit enables watchdog, reset off
// [RULE_07] unit bit: seconds clear, minutes set
// [RULE_08] fast bit ticks thousand times faster
// [RULE_09] zero count stops timer, reset zero
// [RULE_10] count 1..255 units before expiry
// [RULE_11] count write restarts countdown
// [RULE_12] keyboard reload only when enabled
// [RULE_13] force bit times out, self clears
// [RULE_14] status bit reads one after expiry
// [RULE_15] expiry asserts timeout output
// [RULE_16] locked space ignores writes, reads zero
// [RULE_17] prescaled ticks decrement, expire at zero
module wdt_device #(
   parameter longint SEC_CYC = wdt_pkg::SEC_CYC,
   parameter longint MS_CYC  = wdt_pkg::MS_CYC
) (
   input  wire logic ref_clk,
   input  wire logic rst_b,
   wdt_if.device     bus,
   output logic      timeout_out,
   output logic      unlocked
);
   typedef enum logic [2:0] {
      LK_LOCKED = 3'b001,
      LK_HALF   = 3'b010,
      LK_OPEN   = 3'b100
   } lock_t;

   lock_t       lock_r;
   lock_t       lock_nxt;
   logic [7:0]  index_r;
   logic [7:0]  func_r;
   logic [7:0]  act_r;
   logic [7:0]  unit_r;
   logic [7:0]  count_r;
   logic [7:0]  count_nxt;
   logic [7:0]  ctrl_r;
   logic        status_r;
   logic        status_nxt;
   logic [7:0]  rdata_r;
   logic        tick;

   wire         idx_wr   = bus.io_wr && (bus.io_addr == wdt_pkg::PORT_INDEX);
   wire         dat_wr   = bus.io_wr && (bus.io_addr == wdt_pkg::PORT_DATA);
   wire         dat_rd   = bus.io_rd && (bus.io_addr == wdt_pkg::PORT_DATA);
   wire         open_w   = (lock_r == LK_OPEN);
   // [RULE_05] watchdog bank select
   wire         wd_map   = (func_r == wdt_pkg::FUNC_WATCHDOG);
   // [RULE_16] writes gated by lock
   wire         cfg_wr   = dat_wr && open_w;
   wire         wr_func  = cfg_wr && (index_r == wdt_pkg::REG_FUNC_SEL);
   wire         wr_act   = cfg_wr && wd_map && (index_r == wdt_pkg::REG_FUNC_ACT);
   wire         wr_unit  = cfg_wr && wd_map && (index_r == wdt_pkg::REG_UNIT_CFG);
   wire         wr_count = cfg_wr && wd_map && (index_r == wdt_pkg::REG_COUNT);
   wire         wr_ctrl  = cfg_wr && wd_map && (index_r == wdt_pkg::REG_CTRL_STAT);
   wire         enabled  = act_r[wdt_pkg::BIT_ACT_EN];
   wire         force_w  = wr_ctrl && bus.io_wdata[wdt_pkg::BIT_FORCE];
   // [RULE_12] keyboard reload when enabled
   wire         kbd_rel  = bus.kbd_activity && ctrl_r[wdt_pkg::BIT_KBD_EN];
   // [RULE_17] expiry on last tick from one
   wire         expire   = enabled && tick && (count_r == 8'h01) && !wr_count && !kbd_rel;
   // last written count, reused by keyboard reloads
   logic [7:0]  reload_val_r;

   // ============================================================
   // parameter guard: prescale counts must fit 32 bits
   if (MS_CYC < 1 || SEC_CYC < MS_CYC || SEC_CYC > 64'h00000000FFFFFFFF) begin : g_bad_prescale
      $error("wdt_device: prescale counts out of range");
   end

   // ============================================================
   // lock sequence tracker
   // any other index write while locked starts the key pair over
   // [RULE_03] two consecutive unlock keys
   // [RULE_04] lock key closes the space
   always_comb begin
      lock_nxt = lock_r;
      if (idx_wr) begin
         if (bus.io_wdata == wdt_pkg::KEY_LOCK && open_w) begin
            lock_nxt = LK_LOCKED;
         end else if (bus.io_wdata == wdt_pkg::KEY_UNLOCK && !open_w) begin
            lock_nxt = (lock_r == LK_HALF) ? LK_OPEN : LK_HALF;
         end else if (!open_w) begin
            lock_nxt = LK_LOCKED;
         end
      end
   end

   // ============================================================
   // countdown next value
   // [RULE_11] write restarts from new value
   // [RULE_09] zero holds timer stopped
   // [RULE_10] nonzero loads count units
   // reload is ignored at zero so a key press cannot wake a stopped timer
   always_comb begin
      count_nxt = count_r;
      if (wr_count) begin
         count_nxt = bus.io_wdata;
      end else if (kbd_rel && count_r != 8'h00) begin
         count_nxt = reload_val_r;
      end else if (enabled && tick && count_r != 8'h00) begin
         count_nxt = count_r - 8'h01;
      end
   end

   // ============================================================
   // timeout status: a count write clears it and cancels an expiry in the same cycle
   // status stays set until software writes a new count
   // [RULE_14] sticky expiry status
   assign status_nxt = (expire || force_w) ? 1'b1 : (wr_count ? 1'b0 : status_r);

   // ============================================================
   // lock state and index register
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         lock_r  <= LK_LOCKED;
         index_r <= 8'h00;
      end else begin
         lock_r  <= lock_nxt;
         // [RULE_01] index port latches selection
         if (idx_wr && open_w) index_r <= bus.io_wdata;
      end
   end

   // ============================================================
   // configuration registers
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         func_r       <= wdt_pkg::RST_FUNC_SEL;
         act_r        <= wdt_pkg::RST_FUNC_ACT;
         unit_r       <= wdt_pkg::RST_UNIT_CFG;
         ctrl_r       <= wdt_pkg::RST_CTRL;
         reload_val_r <= wdt_pkg::RST_COUNT;
      end else begin
         if (wr_func) func_r <= bus.io_wdata;
         // [RULE_06] activation enables watchdog
         if (wr_act) act_r <= bus.io_wdata;
         // [RULE_07] unit select stored
         if (wr_unit) unit_r <= bus.io_wdata;
         // force bit never stored, so it reads back zero
         if (wr_ctrl) ctrl_r <= {bus.io_wdata[7:6], 6'h00};
         if (wr_count) reload_val_r <= bus.io_wdata;
      end
   end

   // ============================================================
   // timer state and outputs
   // pin copies the status flop so pin and readback never disagree
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         count_r     <= wdt_pkg::RST_COUNT;
         status_r    <= 1'b0;
         timeout_out <= 1'b0;
         unlocked    <= 1'b0;
      end else begin
         count_r     <= count_nxt;
         status_r    <= status_nxt;
         // [RULE_13] force gives immediate timeout
         // [RULE_15] expiry drives timeout output
         timeout_out <= status_nxt;
         unlocked    <= (lock_nxt == LK_OPEN);
      end
   end

   // ============================================================
   // read path: data one cycle after the read strobe
   // idle cycles read zero so no stale register value lingers on the bus
   wire [7:0] ctrl_view = ctrl_r | (8'(status_r) << wdt_pkg::BIT_STATUS);
   wire [7:0] rd_mux =
      (index_r == wdt_pkg::REG_FUNC_SEL)               ? func_r  :
      (wd_map && index_r == wdt_pkg::REG_FUNC_ACT)     ? act_r   :
      (wd_map && index_r == wdt_pkg::REG_UNIT_CFG)     ? unit_r  :
      (wd_map && index_r == wdt_pkg::REG_COUNT)        ? count_r :
      (wd_map && index_r == wdt_pkg::REG_CTRL_STAT)    ? ctrl_view : 8'h00;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_r <= 8'h00;
      end else begin
         // [RULE_16] locked reads return zero
         rdata_r <= (dat_rd && open_w) ? rd_mux : 8'h00;
      end
   end
   assign bus.io_rdata = rdata_r;

   // ============================================================
   // unit prescaler
   // restarted by every count write or reload so the first unit is whole
   // [RULE_08] fast mode divides by thousand
   tick_gen #(
      .SEC_CYC (SEC_CYC),
      .MS_CYC  (MS_CYC)
   ) i_tick_gen (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .clr     (wr_count || kbd_rel),
      .minutes (unit_r[wdt_pkg::BIT_UNIT_MIN]),
      .fast    (unit_r[wdt_pkg::BIT_FAST]),
      .tick    (tick)
   );
endmodule

// >>> hdl/wdt_host.sv
// host end: passes plain i/o port orders straight through as index/data i/o cycles
`timescale 1ns/1ps
module wdt_host (
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   wdt_if.host             bus,
   input  wire logic [7:0] cmd_addr,
   input  wire logic [7:0] cmd_wdata,
   input  wire logic       cmd_wr,
   input  wire logic       cmd_rd,
   output logic [7:0]      cmd_rdata,
   input  wire logic       kbd_in
);
   // ============================================================
   // plain port: cmd_addr is the i/o port, passed straight through
   // no register stage here, so the device acts on the strobe edge itself
   // [RULE_02] software orders index then data writes
   assign bus.io_addr      = cmd_addr;
   assign bus.io_wdata     = cmd_wdata;
   assign bus.io_wr        = cmd_wr;
   assign bus.io_rd        = cmd_rd;
   assign bus.kbd_activity = kbd_in;

   // ============================================================
   // device read flop answers in the cycle after the strobe, zero otherwise
   assign cmd_rdata = bus.io_rdata;
endmodule

// >>> sim/wdt_props.sv
// checker: properties on the watchdog i/o port and device outputs
`timescale 1ns/1ps
module wdt_props (
   input wire logic       ref_clk,
   input wire logic       rst_b,
   input wire logic [7:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic       io_wr,
   input wire logic       io_rd,
   input wire logic [7:0] io_rdata,
   input wire logic       kbd_activity,
   input wire logic       timeout_out,
   input wire logic       unlocked
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   // ============================================================
   // port decode, mirrored from the device side
   logic [7:0] idx_r;
   logic [7:0] fsel_r;
   logic       key_r;
   logic       act_r;
   wire  logic idx_wr = io_wr && (io_addr == wdt_pkg::PORT_INDEX);
   wire  logic key_wr = idx_wr && (io_wdata == wdt_pkg::KEY_UNLOCK);
   wire  logic dat_wr = io_wr && (io_addr == wdt_pkg::PORT_DATA) && unlocked;
   wire  logic wd_sel = fsel_r == wdt_pkg::FUNC_WATCHDOG;
   wire  logic cnt_wr = dat_wr && wd_sel && (idx_r == wdt_pkg::REG_COUNT);
   wire  logic frc_wr = dat_wr && wd_sel && (idx_r == wdt_pkg::REG_CTRL_STAT) && io_wdata[5];
   wire  logic ctl_rd = io_rd && (io_addr == wdt_pkg::PORT_DATA) && unlocked && wd_sel
                        && (idx_r == wdt_pkg::REG_CTRL_STAT);
   // shadow index and function registers follow only what an unlocked device would latch; key_r follows every index write
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         idx_r  <= 8'h00;
         fsel_r <= 8'h00;
         key_r  <= 1'b0;
         act_r  <= 1'b0;
      end else begin
         if (idx_wr && unlocked)
            idx_r <= io_wdata;
         if (idx_wr)
            key_r <= key_wr;
         if (dat_wr && idx_r == wdt_pkg::REG_FUNC_SEL)
            fsel_r <= io_wdata;
         if (dat_wr && wd_sel && idx_r == wdt_pkg::REG_FUNC_ACT)
            act_r <= io_wdata[0];
      end
   end
   // ============================================================
   // key sequence and lock
   unlock_seq_a: assert property (!unlocked && key_wr && key_r |=> unlocked)
      else $error("double key did not unlock");
   key_cause_a: assert property ($rose(unlocked) |-> $past(key_wr))
      else $error("unlock without key write");
   relock_a: assert property (unlocked && idx_wr && io_wdata == wdt_pkg::KEY_LOCK |=> !unlocked)
      else $error("lock key ignored");
   locked_read_a: assert property (!unlocked && io_rd |=> io_rdata == 8'h00)
      else $error("locked read returned data");
   // ============================================================
   // timeout output and status
   to_sticky_a: assert property (timeout_out && !cnt_wr |=> timeout_out)
      else $error("timeout dropped without count write");
   to_clear_a: assert property (cnt_wr |=> !timeout_out)
      else $error("count write kept timeout");
   zero_stop_a: assert property (cnt_wr && io_wdata == 8'h00 |=> !timeout_out [*3])
      else $error("zero count timed out");
   force_to_a: assert property (frc_wr |=> timeout_out)
      else $error("force gave no timeout");
   ctrl_read_a: assert property (ctl_rd |=> io_rdata[5] == 1'b0 && io_rdata[3:0] == 4'h0)
      else $error("control readback wrong");
   en_cause_a: assert property ($rose(timeout_out) |-> $past(act_r) || $past(frc_wr))
      else $error("timeout while disabled");
   // main scenarios reached
   cover property ($rose(unlocked));
   cover property (frc_wr);
   cover property ($rose(timeout_out) && !$past(frc_wr));
   cover property (kbd_activity && unlocked);
endmodule

// >>> sim/test_config_port_watchdog.sv
// testbench: host and device joined, driven through the host command port
`timescale 1ns/1ps
module test_config_port_watchdog;
   // short prescaler counts keep the run brief
   localparam int SEC_T = 2000;
   localparam int MS_T  = 2;
   localparam int FM_T  = 60 * MS_T;
   logic       ref_clk, rst_b, cmd_wr, cmd_rd, kbd_in, timeout_out, unlocked;
   logic [7:0] cmd_addr, cmd_wdata, cmd_rdata;
   int         fail_count, num_checks;
   // ============================================================
   // both ends on one interface, checker beside it
   wdt_if i_wdt_if ();
   wdt_device #(.SEC_CYC(SEC_T), .MS_CYC(MS_T)) i_wdt_device (.ref_clk(ref_clk), .rst_b(rst_b),
      .bus(i_wdt_if.device), .timeout_out(timeout_out), .unlocked(unlocked));
   wdt_host i_wdt_host (.ref_clk(ref_clk), .rst_b(rst_b), .bus(i_wdt_if.host), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .kbd_in(kbd_in));
   wdt_props i_wdt_props (.ref_clk(ref_clk), .rst_b(rst_b), .io_addr(i_wdt_if.io_addr),
      .io_wdata(i_wdt_if.io_wdata), .io_wr(i_wdt_if.io_wr), .io_rd(i_wdt_if.io_rd),
      .io_rdata(i_wdt_if.io_rdata), .kbd_activity(i_wdt_if.kbd_activity),
      .timeout_out(timeout_out), .unlocked(unlocked));
   // 50 ns clock
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // ============================================================
   // access tasks
   task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // settle one ns past the edge before looking
   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      cmd_addr  <= a;
      cmd_wdata <= d;
      cmd_wr    <= 1'b1;
      @(posedge ref_clk);
      cmd_wr    <= 1'b0;
   endtask
   // index written before each data access
   task automatic reg_wr(input logic [7:0] i, input logic [7:0] d);
      wr(8'h2E, i);
      wr(8'h2F, d);
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] i, input logic [7:0] exp, input string what);
      wr(8'h2E, i);
      @(posedge ref_clk);
      cmd_addr <= 8'h2F;
      cmd_rd   <= 1'b1;
      @(posedge ref_clk);
      cmd_rd   <= 1'b0;
      #1;
      check(what, cmd_rdata, exp);
   endtask
   task automatic kbd_pulse();
      @(posedge ref_clk);
      kbd_in <= 1'b1;
      @(posedge ref_clk);
      kbd_in <= 1'b0;
   endtask
   // count cycles to expiry; the first three cover the write landing
   task automatic wait_to(input int lo, input int hi);
      int n;
      n = 3;
      idle(3);
      while (timeout_out !== 1'b1 && n < hi) begin
         idle(1);
         n++;
      end
      if (timeout_out !== 1'b1) begin
         fail_count++;
         $display("[FAIL] expiry expected by %0d seen none", hi);
         test_done();
      end else
         check("early expiry", 8'(n < lo), 8'h00);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ============================================================
   // main sequence
   initial begin
      rst_b = 1'b0;
      cmd_addr = 8'h00;
      cmd_wdata = 8'h00;
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      kbd_in = 1'b0;
      fail_count = 0;
      num_checks = 0;
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      idle(1);
      check("reset timeout", {7'h00, timeout_out}, 8'h00);
      rd(8'hF7, 8'h00, "locked read");
      // broken key sequence first, then a proper one
      wr(8'h2E, 8'h87);
      wr(8'h2E, 8'hF6);
      wr(8'h2E, 8'h87);
      idle(3);
      check("half key", {7'h00, unlocked}, 8'h00);
      wr(8'h2E, 8'h87);
      idle(3);
      check("unlock", {7'h00, unlocked}, 8'h01);
      reg_wr(8'h07, 8'h08);
      reg_wr(8'h30, 8'h01);
      rd(8'h55, 8'h00, "unmapped");
      reg_wr(8'hF6, 8'h00);
      idle(40);
      check("zero count", {7'h00, timeout_out}, 8'h00);
      rd(8'hF7, 8'h00, "status idle");
      // fast seconds, then fast minutes with a restart
      reg_wr(8'hF5, 8'h10);
      reg_wr(8'hF6, 8'h05);
      wait_to(4 * MS_T, 5 * MS_T + 8);
      rd(8'hF7, 8'h10, "status set");
      reg_wr(8'hF5, 8'h18);
      reg_wr(8'hF6, 8'h03);
      idle(200);
      check("cleared", {7'h00, timeout_out}, 8'h00);
      reg_wr(8'hF6, 8'h03);
      wait_to(3 * FM_T - 20, 3 * FM_T + 10);
      // keyboard ignored, then reloading once enabled
      reg_wr(8'hF6, 8'h02);
      idle(150);
      kbd_pulse();
      wait_to(2 * FM_T - 160, 2 * FM_T - 140);
      reg_wr(8'hF7, 8'h40);
      rd(8'hF7, 8'h50, "kbd bit");
      reg_wr(8'hF6, 8'h02);
      idle(150);
      kbd_pulse();
      wait_to(2 * FM_T - 10, 2 * FM_T + 10);
      reg_wr(8'hF5, 8'h00);
      reg_wr(8'hF6, 8'h02);
      wait_to(2 * SEC_T - 20, 2 * SEC_T + 10);
      // disabled function holds its stored count
      reg_wr(8'hF5, 8'h10);
      reg_wr(8'h30, 8'h00);
      reg_wr(8'hF6, 8'h01);
      idle(40);
      check("disabled", {7'h00, timeout_out}, 8'h00);
      reg_wr(8'h30, 8'h01);
      reg_wr(8'hF6, 8'h00);
      reg_wr(8'hF7, 8'h20);
      idle(3);
      check("forced", {7'h00, timeout_out}, 8'h01);
      rd(8'hF7, 8'h10, "force clear");
      reg_wr(8'h07, 8'h00);
      rd(8'hF7, 8'h00, "fn hidden");
      reg_wr(8'h07, 8'h08);
      // relock; a data write may no longer clear the timeout
      wr(8'h2E, 8'hF6);
      wr(8'h2E, 8'hAA);
      idle(3);
      check("relock", {7'h00, unlocked}, 8'h00);
      wr(8'h2F, 8'h05);
      idle(3);
      check("held", {7'h00, timeout_out}, 8'h01);
      test_done();
   end
endmodule
